/* logic/abu_device.sv */
`timescale 1ns/1ps
`include "abu_regs.svh"
// ============================================================
module abu_device (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_b_i,
  abu_if.dev                 bus,
  output abu_pkg::abu_word_t blend_cfg_o,   // current control word
  output logic               pending_o      // results held in buffer
);
  import abu_pkg::*;

  abu_word_t   ctrl_q;                 // blend control register
  abu_word_t   rdata_q;                // read answer data
  logic        rvalid_q;               // read answer pulse
  logic [7:0]  op;                     // operation code
  abu_fmt_t    fmt;                    // five-bit format
  logic        rgb;                    // channel order
  logic        ramp;                   // blend kind
  logic        no_abuf;                // no alpha buffer
  abu_layout_s lay;                    // active layout
  abu_color_s  dcol;                   // decoded destination
  abu_color_s  bcol;                   // blended colour
  abu_word_t   pix;                    // formatted pixel
  logic        out_valid;              // buffer has a result
  logic [63:0] out_word;               // buffer head

  // ==========================================================
  // control register
  // reset to a known word even though software must program it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_q <= `ABU_CTRL_RST;
    end else if (bus.reg_wr && bus.reg_tag == `ABU_TAG_CTRL) begin
      ctrl_q <= bus.reg_wdata & `ABU_CTRL_MASK;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      rvalid_q <= bus.reg_rd;
      if (bus.reg_rd && bus.reg_tag == `ABU_TAG_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (bus.reg_rd) begin
        rdata_q <= '0;                 // unmapped tag reads zero
      end
    end
  end

  assign bus.reg_rdata  = rdata_q;
  assign bus.reg_rvalid = rvalid_q;
  assign blend_cfg_o    = ctrl_q;

  // ==========================================================
  // control fields
  assign op      = ctrl_q[`ABU_OP_MSB:`ABU_OP_LSB];
  assign fmt     = {ctrl_q[`ABU_FMT_EXT_BIT],
                    ctrl_q[`ABU_FMT_MSB:`ABU_FMT_LSB]};
  assign rgb     = ctrl_q[`ABU_ORDER_BIT];
  assign ramp    = ctrl_q[`ABU_KIND_BIT];
  assign no_abuf = ctrl_q[`ABU_NOALPHA_BIT];

  // ==========================================================
  // layout table
  function automatic abu_layout_s mk(input int rw, rp, gw, gp,
                                     input int bw, bp, aw, ap);
    mk = '{5'(rw), 5'(rp), 5'(gw), 5'(gp),
           5'(bw), 5'(bp), 5'(aw), 5'(ap)};
  endfunction

  // reserved codes decode to nothing, leaving only default alpha
  function automatic abu_layout_s layout(input abu_fmt_t c,
                                         input logic o);
    layout = '0;
    if (!o) begin
      case (c)
        `ABU_FMT_8888:   layout = mk(8, 0, 8, 8, 8, 16, 8, 24);
        `ABU_FMT_5551_F: layout = mk(5, 0, 5, 5, 5, 10, 1, 15);
        `ABU_FMT_4444:   layout = mk(4, 0, 4, 4, 4, 8, 4, 12);
        `ABU_FMT_332_F:  layout = mk(3, 0, 3, 3, 2, 6, 0, 0);
        `ABU_FMT_332_B:  layout = mk(3, 8, 3, 11, 2, 14, 0, 0);
        `ABU_FMT_2321_F: layout = mk(2, 0, 3, 2, 2, 5, 1, 7);
        `ABU_FMT_2321_B: layout = mk(2, 8, 3, 10, 2, 13, 1, 15);
        `ABU_FMT_232_FO: layout = mk(2, 0, 3, 2, 2, 5, 0, 0);
        `ABU_FMT_232_BO: layout = mk(2, 8, 3, 10, 2, 13, 0, 0);
        `ABU_FMT_5551_B: layout = mk(5, 16, 5, 21, 5, 26, 1, 31);
        `ABU_FMT_IDX8:   layout = mk(8, 0, 0, 0, 0, 0, 0, 0);
        `ABU_FMT_565_F:  layout = mk(5, 0, 6, 5, 5, 11, 0, 0);
        `ABU_FMT_565_B:  layout = mk(5, 16, 6, 21, 5, 27, 0, 0);
        default:         layout = '0;
      endcase
    end else begin
      case (c)
        `ABU_FMT_8888:   layout = mk(8, 16, 8, 8, 8, 0, 8, 24);
        `ABU_FMT_5551_F: layout = mk(5, 10, 5, 5, 5, 0, 1, 15);
        `ABU_FMT_4444:   layout = mk(4, 8, 4, 4, 4, 0, 4, 12);
        `ABU_FMT_332_F:  layout = mk(3, 5, 3, 2, 2, 0, 0, 0);
        `ABU_FMT_332_B:  layout = mk(3, 13, 3, 10, 2, 8, 0, 0);
        `ABU_FMT_2321_F: layout = mk(2, 5, 3, 2, 2, 0, 1, 7);
        `ABU_FMT_2321_B: layout = mk(2, 13, 3, 10, 2, 8, 1, 15);
        `ABU_FMT_232_FO: layout = mk(2, 5, 3, 2, 2, 0, 0, 0);
        `ABU_FMT_232_BO: layout = mk(2, 13, 3, 10, 2, 8, 0, 0);
        `ABU_FMT_5551_B: layout = mk(5, 26, 5, 21, 5, 16, 1, 31);
        `ABU_FMT_IDX8:   layout = mk(8, 0, 0, 0, 0, 0, 0, 0);
        `ABU_FMT_565_F:  layout = mk(5, 11, 6, 5, 5, 0, 0, 0);
        `ABU_FMT_565_B:  layout = mk(5, 27, 6, 21, 5, 16, 0, 0);
        default:         layout = '0;
      endcase
    end
  endfunction

  // ==========================================================
  // field extract and place
  // extracted fields are left justified into eight bits
  function automatic logic [7:0] ext(input abu_word_t wd,
                                     input logic [4:0] w,
                                     input logic [4:0] p);
    abu_word_t  sh;
    logic [7:0] m;
    sh  = wd >> p;
    m   = 8'((16'h0001 << w) - 16'h0001);
    ext = (sh[7:0] & m) << (5'd8 - w);
  endfunction

  // only the top bits of the component survive packing
  function automatic abu_word_t put(input logic [7:0] cv,
                                    input logic [4:0] w,
                                    input logic [4:0] p);
    logic [7:0] v;
    v   = cv >> (5'd8 - w);
    put = (w == 5'd0) ? '0 : ({24'h0, v} << p);
  endfunction

  // ==========================================================
  // per component arithmetic, rounded, premultiplied saturates
  function automatic logic [7:0] mix(input logic [7:0] s,
                                     input logic [7:0] d,
                                     input logic [7:0] a);
    logic [7:0]  ia;
    logic [16:0] acc;
    logic [16:0] dpart;
    logic [8:0]  sum;
    ia    = 8'hff - a;
    acc   = 17'(s * a) + 17'(d * ia) + `ABU_ROUND;
    dpart = 17'(d * ia) + `ABU_ROUND;
    sum   = {1'b0, s} + {1'b0, dpart[15:8]};
    case (op)
      `ABU_OP_BLEND:   mix = acc[15:8];
      `ABU_OP_PRE_MUL: mix = sum[8] ? 8'hff : sum[7:0];
      `ABU_OP_FORMAT:  mix = d;
      default:         mix = d;        // unknown codes keep memory
    endcase
  endfunction

  // ==========================================================
  // destination decode
  assign lay    = layout(fmt, rgb);
  assign dcol.r = ext(bus.frag_dst, lay.rw, lay.rp);
  assign dcol.g = ext(bus.frag_dst, lay.gw, lay.gp);
  assign dcol.b = ext(bus.frag_dst, lay.bw, lay.bp);
  // no alpha in memory, so use the fixed default
  assign dcol.a = (lay.aw == 5'd0 || no_abuf) ? `ABU_ALPHA_DEF
                : ext(bus.frag_dst, lay.aw, lay.ap);

  // ==========================================================
  // blend; ramp blends intensity and alpha, and copies intensity across
  always_comb begin
    bcol.r = mix(bus.frag_src.r, dcol.r, bus.frag_src.a);
    bcol.a = mix(bus.frag_src.a, dcol.a, bus.frag_src.a);
    if (ramp) begin
      bcol.g = bcol.r;
      bcol.b = bcol.r;
    end else begin
      bcol.g = mix(bus.frag_src.g, dcol.g, bus.frag_src.a);
      bcol.b = mix(bus.frag_src.b, dcol.b, bus.frag_src.a);
    end
  end

  // ==========================================================
  // pack and replicate for double buffering
  always_comb begin
    abu_word_t  pk;
    logic [7:0] by;
    pk  = put(bcol.r, lay.rw, lay.rp) | put(bcol.g, lay.gw, lay.gp)
        | put(bcol.b, lay.bw, lay.bp) | put(bcol.a, lay.aw, lay.ap);
    by  = pk[7:0] | pk[15:8];
    pix = pk;
    case (fmt)
      `ABU_FMT_5551_F, `ABU_FMT_4444, `ABU_FMT_565_F:
        pix = {pk[15:0], pk[15:0]};
      `ABU_FMT_5551_B, `ABU_FMT_565_B:
        pix = {pk[31:16], pk[31:16]};
      `ABU_FMT_232_FO, `ABU_FMT_232_BO:
        pix = {4{8'({1'b0, by[6:0]}) + `ABU_OFFSET_ADD}};
      `ABU_FMT_332_F, `ABU_FMT_332_B, `ABU_FMT_2321_F,
      `ABU_FMT_2321_B, `ABU_FMT_IDX8:
        pix = {4{by}};
      default:
        pix = pk;
    endcase
  end

  // ==========================================================
  // result buffer, a stall downstream stalls the fragment input
  abu_buf #(
    .W (64),
    .D (2)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (bus.frag_valid),
    .in_ready_o  (bus.frag_ready),
    .in_data_i   ({pix, bcol}),
    .out_valid_o (out_valid),
    .out_ready_i (bus.res_ready),
    .out_data_o  (out_word)
  );

  assign bus.res_valid = out_valid;
  assign bus.res_pixel = out_word[63:32];
  assign bus.res_color = out_word[31:0];
  assign pending_o     = out_valid;
endmodule

/* logic/abu_regs.svh */
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
// ============================================================
// register map
`define ABU_TAG_W         12
`define ABU_TAG_CTRL      12'h102
`define ABU_CTRL_RST      32'h0000_0000
`define ABU_CTRL_MASK     32'h0001_7fff
// ============================================================
// control field positions
`define ABU_OP_LSB        0
`define ABU_OP_MSB        7
`define ABU_FMT_LSB       8
`define ABU_FMT_MSB       11
`define ABU_NOALPHA_BIT   12
`define ABU_ORDER_BIT     13
`define ABU_KIND_BIT      14
`define ABU_FMT_EXT_BIT   16
// ============================================================
// blend operation codes
`define ABU_OP_FORMAT     8'h10
`define ABU_OP_PRE_MUL    8'h51
`define ABU_OP_BLEND      8'h54
// ============================================================
// pixel format codes
`define ABU_FMT_8888      5'h00
`define ABU_FMT_5551_F    5'h01
`define ABU_FMT_4444      5'h02
`define ABU_FMT_332_F     5'h05
`define ABU_FMT_332_B     5'h06
`define ABU_FMT_2321_F    5'h09
`define ABU_FMT_2321_B    5'h0a
`define ABU_FMT_232_FO    5'h0b
`define ABU_FMT_232_BO    5'h0c
`define ABU_FMT_5551_B    5'h0d
`define ABU_FMT_IDX8      5'h0e
`define ABU_FMT_565_F     5'h10
`define ABU_FMT_565_B     5'h11
// ============================================================
// datapath constants
`define ABU_ALPHA_DEF     8'hf8
`define ABU_OFFSET_ADD    8'h40
`define ABU_ROUND         17'h00080
`endif

/* logic/abu_pkg.sv */
package abu_pkg;
  // ==========================================================
  // types shared by both ends
  typedef logic [4:0]  abu_fmt_t;     // five-bit pixel format code
  typedef logic [31:0] abu_word_t;    // one pixel or register word
  typedef struct packed {
    logic [7:0] a;                    // alpha
    logic [7:0] b;                    // blue
    logic [7:0] g;                    // green
    logic [7:0] r;                    // red, or colour index
  } abu_color_s;
  typedef struct packed {
    logic [4:0] rw, rp;               // red bits and position
    logic [4:0] gw, gp;               // green bits and position
    logic [4:0] bw, bp;               // blue bits and position
    logic [4:0] aw, ap;               // alpha bits and position
  } abu_layout_s;
endpackage

/* logic/abu_if.sv */
`timescale 1ns/1ps
`include "abu_regs.svh"
interface abu_if;
  // ==========================================================
  // register access, by tag
  logic                     reg_wr;     // write strobe
  logic                     reg_rd;     // read strobe
  logic [`ABU_TAG_W-1:0]    reg_tag;    // register tag
  abu_pkg::abu_word_t       reg_wdata;  // write data
  abu_pkg::abu_word_t       reg_rdata;  // read data
  logic                     reg_rvalid; // read answer pulse
  // ==========================================================
  // fragment stream in, blended pixel stream out
  logic                     frag_valid; // source and dest paired
  logic                     frag_ready; // device can take it
  abu_pkg::abu_color_s      frag_src;   // source colour
  abu_pkg::abu_word_t       frag_dst;   // raw destination pixel
  logic                     res_valid;  // result available
  logic                     res_ready;  // writer takes result
  abu_pkg::abu_word_t       res_pixel;  // formatted pixel word
  abu_pkg::abu_color_s      res_color;  // blended colour
  modport dev (
    input  reg_wr, reg_rd, reg_tag, reg_wdata,
    output reg_rdata, reg_rvalid,
    input  frag_valid, frag_src, frag_dst, res_ready,
    output frag_ready, res_valid, res_pixel, res_color
  );
  modport hst (
    output reg_wr, reg_rd, reg_tag, reg_wdata,
    input  reg_rdata, reg_rvalid,
    output frag_valid, frag_src, frag_dst, res_ready,
    input  frag_ready, res_valid, res_pixel, res_color
  );
endinterface

/* logic/abu_buf.sv */
`timescale 1ns/1ps
module abu_buf #(
  parameter int W = 64,                   // word width
  parameter int D = 2                     // entries
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem_q [D];              // storage array
  logic [AW-1:0] wr_q;                   // write pointer
  logic [AW-1:0] rd_q;                   // read pointer
  logic [CW-1:0] cnt_q;                  // entries held
  logic          push;                   // word enters
  logic          pop;                    // word leaves

  // ==========================================================
  // handshake, honest full and empty
  assign in_ready_o  = (cnt_q != CW'(D));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  // pointer advance with wrap, works for any depth
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule

/* logic/abu_host.sv */
`timescale 1ns/1ps
`include "abu_regs.svh"
module abu_host (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  abu_if.hst                         bus,
  input  wire logic                  cfg_wr_i,     // write request
  input  wire logic                  cfg_rd_i,     // read request
  input  wire logic [`ABU_TAG_W-1:0] cfg_tag_i,    // register tag
  input  wire abu_pkg::abu_word_t    cfg_wdata_i,  // write data
  output abu_pkg::abu_word_t         cfg_rdata_o,  // read data
  output logic                       cfg_rvalid_o, // read answer
  output logic                       cfg_err_o,    // refused write
  output logic                       ready_o,      // control set
  input  wire logic                  frag_valid_i,
  output logic                       frag_ready_o,
  input  wire abu_pkg::abu_color_s   frag_src_i,
  input  wire abu_pkg::abu_word_t    frag_dst_i,
  output logic                       res_valid_o,
  input  wire logic                  res_ready_i,
  output abu_pkg::abu_word_t         res_pixel_o,
  output abu_pkg::abu_color_s        res_color_o
);
  import abu_pkg::*;

  logic                  wr_q;       // write strobe to device
  logic                  rd_q;       // read strobe to device
  logic [`ABU_TAG_W-1:0] tag_q;      // tag to device
  abu_word_t             wdata_q;    // data to device
  logic                  err_q;      // refused write pulse
  logic                  prog_q;     // control has been written
  logic                  hold_q;     // fragment stage full
  abu_color_s            src_q;      // held source
  abu_word_t             dst_q;      // held destination
  logic                  legal;      // format code is listed
  logic                  take;       // user fragment accepted

  // only listed format codes may reach the device
  function automatic logic fmt_ok(input abu_word_t w);
    case ({w[`ABU_FMT_EXT_BIT], w[`ABU_FMT_MSB:`ABU_FMT_LSB]})
      `ABU_FMT_8888, `ABU_FMT_5551_F, `ABU_FMT_4444, `ABU_FMT_332_F,
      `ABU_FMT_332_B, `ABU_FMT_2321_F, `ABU_FMT_2321_B,
      `ABU_FMT_232_FO, `ABU_FMT_232_BO, `ABU_FMT_5551_B,
      `ABU_FMT_IDX8, `ABU_FMT_565_F, `ABU_FMT_565_B: fmt_ok = 1'b1;
      default: fmt_ok = 1'b0;
    endcase
  endfunction

  assign legal = (cfg_tag_i != `ABU_TAG_CTRL) || fmt_ok(cfg_wdata_i);

  // ==========================================================
  // register requests, one-cycle strobes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      err_q   <= 1'b0;
      tag_q   <= '0;
      wdata_q <= '0;
    end else begin
      wr_q  <= cfg_wr_i && legal;
      err_q <= cfg_wr_i && !legal;
      rd_q  <= cfg_rd_i && !cfg_wr_i;
      if (cfg_wr_i || cfg_rd_i) begin
        tag_q   <= cfg_tag_i;
        // reserved bits go out as zero on control tag writes only
        wdata_q <= (cfg_tag_i == `ABU_TAG_CTRL)
                 ? (cfg_wdata_i & `ABU_CTRL_MASK) : cfg_wdata_i;
      end
    end
  end

  // fragments wait until the control word has been written
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prog_q <= 1'b0;
    end else if (wr_q && tag_q == `ABU_TAG_CTRL) begin
      prog_q <= 1'b1;
    end
  end

  // ==========================================================
  // fragment stage, one word per cycle when downstream flows
  assign frag_ready_o = prog_q && (!hold_q || bus.frag_ready);
  assign take         = frag_valid_i && frag_ready_o;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hold_q <= 1'b0;
      src_q  <= '0;
      dst_q  <= '0;
    end else begin
      if (take) begin
        hold_q <= 1'b1;
        src_q  <= frag_src_i;
        dst_q  <= frag_dst_i;
      end else if (bus.frag_ready) begin
        hold_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interface drive and return path
  assign bus.reg_wr     = wr_q;
  assign bus.reg_rd     = rd_q;
  assign bus.reg_tag    = tag_q;
  assign bus.reg_wdata  = wdata_q;
  assign bus.frag_valid = hold_q;
  assign bus.frag_src   = src_q;
  assign bus.frag_dst   = dst_q;
  assign bus.res_ready  = res_ready_i;
  assign res_valid_o    = bus.res_valid;
  assign res_pixel_o    = bus.res_pixel;
  assign res_color_o    = bus.res_color;
  // reserved read bits are not trusted by anything here
  assign cfg_rdata_o    = bus.reg_rdata;
  assign cfg_rvalid_o   = bus.reg_rvalid;
  assign cfg_err_o      = err_q;
  assign ready_o        = prog_q;
endmodule

/* verification/abu_monitor.sv */
`timescale 1ns/1ps
`include "abu_regs.svh"
// ============================================================
// watches the link between host end and device end
module abu_monitor (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [`ABU_TAG_W-1:0] reg_tag,
  input wire abu_pkg::abu_word_t    reg_wdata,
  input wire abu_pkg::abu_word_t    reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic                  frag_valid,
  input wire logic                  frag_ready,
  input wire logic                  res_valid,
  input wire logic                  res_ready,
  input wire abu_pkg::abu_word_t    res_pixel,
  input wire abu_pkg::abu_color_s   res_color
);
  import abu_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // register link: write then read back
  sequence s_ctrl_wr; reg_wr && reg_tag == `ABU_TAG_CTRL; endsequence
  sequence s_rd_only; reg_rd && !reg_wr; endsequence
  property p_rd_ans; s_rd_only |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read strobe got no answer");
  property p_no_spur; !reg_rd |=> !reg_rvalid; endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("answer without read");
  property p_wr_rd;
    s_ctrl_wr ##1 s_rd_only |=>
      reg_rdata == ($past(reg_wdata, 2) & `ABU_CTRL_MASK);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("control read back differs");
  property p_unmap;
    s_rd_only and (reg_tag != `ABU_TAG_CTRL) |=> reg_rdata == '0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // reserved bits must leave the host as zero
  property p_resv; reg_wr |-> (reg_wdata & ~`ABU_CTRL_MASK) == '0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits written nonzero");
  // ==========================================================
  // result stream: no loss while stalled
  property p_hold;
    res_valid && !res_ready |=>
      res_valid && $stable(res_pixel) && $stable(res_color);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled result changed");
  property p_lat; frag_valid && frag_ready |=> res_valid; endproperty
  a_lat: assert property (p_lat)
    else $error("taken fragment gave no result");
  property p_drop; $fell(res_valid) |-> $past(res_ready); endproperty
  a_drop: assert property (p_drop)
    else $error("result dropped without ready");
endmodule

/* verification/tb_alpha_blend_unit.sv */
`timescale 1ns/1ps
`include "abu_regs.svh"
module tb_alpha_blend_unit;
  import abu_pkg::*;
  // ==========================================================
  // stimulus, model state and counters
  logic                  ref_clk_i = 0, rst_b_i = 0, cfg_wr_i = 0;
  logic                  cfg_rd_i = 0, frag_valid_i = 0, res_ready_i = 0;
  logic [`ABU_TAG_W-1:0] cfg_tag_i = '0;
  abu_word_t             cfg_wdata_i = '0, frag_dst_i = '0;
  abu_word_t             cfg_rdata_o, res_pixel_o, blend_cfg_o;
  abu_color_s            frag_src_i = '0, res_color_o;
  logic                  cfg_rvalid_o, cfg_err_o, ready_o, pending_o;
  logic                  frag_ready_o, res_valid_o, tk, pp;
  logic [31:0]           lf = 32'h00ea, ctrl_m = '0, d;
  logic [64:0]           expq[$], e;   // {color valid, pixel, color}
  int                    num_errors = 0, cmp_count = 0, cyc = 0;
  int                    sent = 0, nfrag = 0, f;
  bit                    run = 0;
  int fmts[13] = '{0, 1, 2, 5, 6, 9, 10, 11, 12, 13, 14, 16, 17};
  int ops[4] = '{8'h54, 8'h51, 8'h10, 8'h00};
  always #20 ref_clk_i = ~ref_clk_i;
  abu_if bus_if ();
  abu_host abu_host_i (.ref_clk_i, .rst_b_i, .bus(bus_if), .cfg_wr_i,
    .cfg_rd_i, .cfg_tag_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o,
    .cfg_err_o, .ready_o, .frag_valid_i, .frag_ready_o, .frag_src_i,
    .frag_dst_i, .res_valid_o, .res_ready_i, .res_pixel_o, .res_color_o);
  abu_device abu_device_i (.ref_clk_i, .rst_b_i, .bus(bus_if),
    .blend_cfg_o, .pending_o);
  abu_monitor abu_monitor_i (.ref_clk_i, .rst_b_i,
    .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_tag(bus_if.reg_tag), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .reg_rvalid(bus_if.reg_rvalid),
    .frag_valid(bus_if.frag_valid), .frag_ready(bus_if.frag_ready),
    .res_valid(bus_if.res_valid), .res_ready(bus_if.res_ready),
    .res_pixel(bus_if.res_pixel), .res_color(bus_if.res_color));
  // ==========================================================
  // reference model: pass-through for packed formats, full maths
  // only for 8:8:8:8 to keep the model small
  function automatic logic [64:0] mdl(abu_color_s s, abu_word_t w);
    int fm, o, a, c[4], db[4];
    logic [7:0] by;
    fm = {ctrl_m[16], ctrl_m[11:8]};
    o = ctrl_m[7:0];
    a = s.a;
    by = (fm inside {6, 10, 12}) ? w[15:8] : w[7:0];
    if (fm inside {11, 12}) by = {1'b0, by[6:0]} + 8'h40;
    case (fm)
      0: ;
      1, 2, 16: return {1'b0, {2{w[15:0]}}, 32'h0};
      13, 17: return {1'b0, {2{w[31:16]}}, 32'h0};
      default: return {1'b0, {4{by}}, 32'h0};
    endcase
    db = '{ctrl_m[13] ? w[23:16] : w[7:0], w[15:8],
           ctrl_m[13] ? w[7:0] : w[23:16], ctrl_m[12] ? 8'hf8 : w[31:24]};
    for (int i = 0; i < 4; i++) begin
      c[i] = (o == 8'h54) ? (s[8*i+:8] * a + db[i] * (255 - a) + 128) >> 8
           : (o == 8'h51) ? s[8*i+:8] + ((db[i] * (255 - a) + 128) >> 8)
           : db[i];
      if (c[i] > 255) c[i] = 255;   // premultiplied sum saturates
    end
    if (ctrl_m[14]) begin c[1] = c[0]; c[2] = c[0]; end
    return {1'b1, c[3][7:0], ctrl_m[13] ? {c[0][7:0], c[1][7:0], c[2][7:0]}
      : {c[2][7:0], c[1][7:0], c[0][7:0]},
      c[3][7:0], c[2][7:0], c[1][7:0], c[0][7:0]};
  endfunction
  // next pseudo random word, maximal length taps
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // write a tag, then read it straight back
  task cfg(input logic [11:0] t, input logic [31:0] w, input bit bad,
           input logic [31:0] x);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1; cfg_tag_i <= t; cfg_wdata_i <= w;
    @(posedge ref_clk_i);
    cfg_wr_i <= 0; cfg_rd_i <= 1;
    #1 chk("err", {31'h0, bad}, {31'h0, cfg_err_o});
    @(posedge ref_clk_i);
    cfg_rd_i <= 0;
    @(posedge ref_clk_i);
    #1 chk("rdata", x, cfg_rdata_o);
    chk("rvalid", 1, {31'h0, cfg_rvalid_o});
  endtask
  // ==========================================================
  // stream: decide at negedge, drive at posedge
  always @(negedge ref_clk_i) begin
    tk = frag_valid_i && frag_ready_o;
    pp = res_valid_o && res_ready_i;
    if (tk) begin expq.push_back(mdl(frag_src_i, frag_dst_i)); sent++; end
    if (pp) begin
      e = expq.pop_front();
      chk("pixel", e[63:32], res_pixel_o);
      if (e[64]) chk("color", e[31:0], res_color_o);
    end
  end
  always @(posedge ref_clk_i) begin
    lf <= lfsr(lf);
    cyc <= cyc + 1;
    res_ready_i <= !run || lf[3];   // random stalls fill the buffer
    if (!frag_valid_i || tk) begin
      frag_valid_i <= run && sent < nfrag && lf[0];
      frag_src_i <= lf;
      frag_dst_i <= {lf[15:0], lf[31:16]} ^ cyc;
    end
    if (cyc == 20000) begin num_errors++; tally_and_finish(); end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1;
    #1 chk("frag_ready", 0, {31'h0, frag_ready_o});
    cfg(12'h0ff, 32'h5, 0, 0);
    cfg(`ABU_TAG_CTRL, 32'h0300, 1, 0);
    chk("ready", 0, {31'h0, ready_o});
    for (int j = 0; j < 21; j++) begin
      f = (j < 8) ? 0 : fmts[j-8];
      d = (j < 8) ? (lf & 32'hfffe_f000) | ops[j%4]
          : ((f & 15) << 8) | ((f >> 4) << 16) | 8'h10;
      cfg(`ABU_TAG_CTRL, d, 0, d & `ABU_CTRL_MASK);
      ctrl_m = d & `ABU_CTRL_MASK;
      chk("cfg", ctrl_m, blend_cfg_o);
      nfrag = 12; sent = 0; run = 1;
      while (sent < nfrag || expq.size() > 0) @(posedge ref_clk_i);
      run = 0;
      #1 chk("pending", 0, {31'h0, pending_o});
    end
    chk("ready", 1, {31'h0, ready_o});
    tally_and_finish();
  end
endmodule
